// ==== hdl/rfsc_pkg.sv ====
// package for the radio front-end and synthesizer calibration register bank
// assumes a 32-bit avalon-mm slave with byte addresses, one register per aligned word
// Notes on behaviour
// - rx front-end bits 7:6 set low-noise amp bias and bits 5:4 amp-to-mixer bias, both read/write, reset 01.
// - rx front-end bits 3:2 set rx local oscillator buffer bias (reset 01) and bits 1:0 mixer bias (reset 10).
// - tx front-end bits 5:4 set tx local oscillator buffer bias, read/write, reset 01.
// - charge-pump calibration register bits 7:6 hold the calibration configuration, read/write, reset 10.
// - a zero in bits 5:4 of the charge-pump calibration register skips the charge-pump calibration stage; reset 10.
// - bits 3:0 of the charge-pump calibration register hold the charge-pump current result, reset 1001.
// - bit 5 of the oscillator calibration register selects the low (0) or high (1) oscillator core, reset 0.
// - bits 4:0 of the oscillator calibration register capture the current result and take software overrides, reset 01010.
// - both calibration registers return to reset values on wake from sleep mode two or three.
package rfsc_pkg;
   localparam int           ADDR_W        = 18;
   // printed offsets are register indices; byte address is four times the index
   localparam logic [15:0]  IDX_RX_FE     = 16'hDF1A;
   localparam logic [15:0]  IDX_TX_FE     = 16'hDF1B;
   localparam logic [15:0]  IDX_CAL_CP    = 16'hDF1C;
   localparam logic [15:0]  IDX_CAL_OSC   = 16'hDF1D;
   localparam logic [17:0]  ADDR_RX_FE    = {IDX_RX_FE, 2'h0};
   localparam logic [17:0]  ADDR_TX_FE    = {IDX_TX_FE, 2'h0};
   localparam logic [17:0]  ADDR_CAL_CP   = {IDX_CAL_CP, 2'h0};
   localparam logic [17:0]  ADDR_CAL_OSC  = {IDX_CAL_OSC, 2'h0};
   localparam logic [7:0]   RST_RX_FE     = 8'h56;
   localparam logic [7:0]   RST_TX_FE     = 8'h10;
   localparam logic [7:0]   RST_CAL_CP    = 8'hA9;
   localparam logic [7:0]   RST_CAL_OSC   = 8'h0A;
   localparam logic [7:0]   MASK_RX_FE    = 8'hFF;
   localparam logic [7:0]   MASK_TX_FE    = 8'h37;
   localparam logic [7:0]   MASK_CAL_CP   = 8'hFF;
   localparam logic [7:0]   MASK_CAL_OSC  = 8'h3F;
   localparam logic [7:0]   MASK_CP_RES   = 8'h0F;
   localparam logic [7:0]   MASK_OSC_RES  = 8'h1F;

   typedef struct packed {
      logic [1:0] low_noise_amp_bias;
      logic [1:0] amp_to_mixer_bias;
      logic [1:0] rx_local_osc_buffer_bias;
      logic [1:0] mixer_bias;
      logic [1:0] tx_local_osc_buffer_bias;
      logic [2:0] tx_reserved;
      logic [1:0] cal_config;
      logic [1:0] charge_pump_cal_enable;
      logic [3:0] charge_pump_current;
      logic       oscillator_core_select;
      logic [4:0] oscillator_current;
   } rfsc_fe_cfg_t;

   typedef struct packed {
      logic [7:0] rx_front_end_config;
      logic [7:0] tx_front_end_config;
      logic [7:0] synth_cal_charge_pump;
      logic [7:0] synth_cal_oscillator;
      logic       ack;
      logic [7:0] rdata;
   } rfsc_state_t;
endpackage : rfsc_pkg

// ==== hdl/rfsc_regs.sv ====
// register bank for rx/tx front-end bias and synthesizer calibration results
// assumes a single 200 mhz clock, an avalon-mm master, a calibration engine and a power manager on the same clock
//
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module rfsc_regs
   import rfsc_pkg::*;
(
   input  wire logic                 core_clk_in,
   input  wire logic                 reset_n_in,
   input  wire logic [ADDR_W-1:0]    avs_address_in,
   input  wire logic                 avs_read_in,
   input  wire logic                 avs_write_in,
   input  wire logic [31:0]          avs_writedata_in,
   input  wire logic [3:0]           avs_byteenable_in,
   output logic      [31:0]          avs_readdata_out,
   output logic                      avs_waitrequest_out,
   input  wire logic                 cp_cal_done_in,
   input  wire logic [3:0]           cp_cal_result_in,
   input  wire logic                 osc_cal_done_in,
   input  wire logic [4:0]           osc_cal_result_in,
   input  wire logic                 deep_sleep_wake_in,
   output logic                      cp_cal_stage_enable_out,
   output rfsc_fe_cfg_t              fe_cfg_out
);
   rfsc_state_t s;
   rfsc_state_t next_s;
   logic        req;
   logic        wr_go;
   logic        cp_take;
   logic [7:0]  rd_val;
   logic        hit_rx;
   logic        hit_tx;
   logic        hit_cp;
   logic        hit_osc;
   logic        hit_any;

   assign req   = avs_read_in | avs_write_in;
   // write lands on the edge where the master sees waitrequest low
   assign wr_go = avs_write_in & s.ack & avs_byteenable_in[0];
   // skipped charge-pump stage must not disturb the stored result
   assign cp_take = cp_cal_done_in & (s.synth_cal_charge_pump[5:4] != 2'h0);
   // address decode shared by the checks below
   assign hit_rx  = (avs_address_in == ADDR_RX_FE);
   assign hit_tx  = (avs_address_in == ADDR_TX_FE);
   assign hit_cp  = (avs_address_in == ADDR_CAL_CP);
   assign hit_osc = (avs_address_in == ADDR_CAL_OSC);
   assign hit_any = hit_rx | hit_tx | hit_cp | hit_osc;

   always_comb begin
      rd_val = 8'h00;
      if (avs_address_in == ADDR_RX_FE) begin
         rd_val = s.rx_front_end_config;
      end else if (avs_address_in == ADDR_TX_FE) begin
         rd_val = s.tx_front_end_config;
      end else if (avs_address_in == ADDR_CAL_CP) begin
         rd_val = s.synth_cal_charge_pump;
      end else if (avs_address_in == ADDR_CAL_OSC) begin
         rd_val = s.synth_cal_oscillator;
      end
   end

   always_comb begin
      next_s     = s;
      next_s.ack = 1'b0;
      if (req && !s.ack) begin
         next_s.ack = 1'b1;
         if (avs_read_in) begin
            next_s.rdata = rd_val;
         end
      end
      if (wr_go) begin
         if (avs_address_in == ADDR_RX_FE) begin
            next_s.rx_front_end_config = avs_writedata_in[7:0] & MASK_RX_FE;
         end else if (avs_address_in == ADDR_TX_FE) begin
            // reserved bits 2:0 stored as written; software keeps them zero
            next_s.tx_front_end_config = avs_writedata_in[7:0] & MASK_TX_FE;
         end else if (avs_address_in == ADDR_CAL_CP) begin
            next_s.synth_cal_charge_pump = avs_writedata_in[7:0] & MASK_CAL_CP;
         end else if (avs_address_in == ADDR_CAL_OSC) begin
            next_s.synth_cal_oscillator = avs_writedata_in[7:0] & MASK_CAL_OSC;
         end
      end
      // hardware capture after the software write so a result in the same cycle wins
      if (cp_take) begin
         next_s.synth_cal_charge_pump = (next_s.synth_cal_charge_pump & ~MASK_CP_RES)
                                      | {4'h0, cp_cal_result_in};
      end
      if (osc_cal_done_in) begin
         next_s.synth_cal_oscillator = (next_s.synth_cal_oscillator & ~MASK_OSC_RES)
                                     | {3'h0, osc_cal_result_in};
      end
      if (deep_sleep_wake_in) begin
         next_s.synth_cal_charge_pump = RST_CAL_CP;
         next_s.synth_cal_oscillator  = RST_CAL_OSC;
      end
   end

   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         s.rx_front_end_config   <= RST_RX_FE;
         s.tx_front_end_config   <= RST_TX_FE;
         s.synth_cal_charge_pump <= RST_CAL_CP;
         s.synth_cal_oscillator  <= RST_CAL_OSC;
         s.ack                   <= 1'b0;
         s.rdata                 <= 8'h00;
      end else begin
         s <= next_s;
      end
   end

   assign avs_waitrequest_out     = req & ~s.ack;
   assign avs_readdata_out        = {24'h000000, s.rdata};
   assign cp_cal_stage_enable_out = (s.synth_cal_charge_pump[5:4] != 2'h0);

   always_comb begin
      fe_cfg_out.low_noise_amp_bias       = s.rx_front_end_config[7:6];
      fe_cfg_out.amp_to_mixer_bias        = s.rx_front_end_config[5:4];
      fe_cfg_out.rx_local_osc_buffer_bias = s.rx_front_end_config[3:2];
      fe_cfg_out.mixer_bias               = s.rx_front_end_config[1:0];
      fe_cfg_out.tx_local_osc_buffer_bias = s.tx_front_end_config[5:4];
      fe_cfg_out.tx_reserved              = s.tx_front_end_config[2:0];
      fe_cfg_out.cal_config               = s.synth_cal_charge_pump[7:6];
      fe_cfg_out.charge_pump_cal_enable   = s.synth_cal_charge_pump[5:4];
      fe_cfg_out.charge_pump_current      = s.synth_cal_charge_pump[3:0];
      fe_cfg_out.oscillator_core_select   = s.synth_cal_oscillator[5];
      fe_cfg_out.oscillator_current       = s.synth_cal_oscillator[4:0];
   end

   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!reset_n_in);

   a_bus_one_wait: assert property (avs_waitrequest_out |=> (!avs_waitrequest_out || !req))
      else $error("waitrequest held more than one cycle");
   a_rx_write_lands: assert property (wr_go && avs_address_in == ADDR_RX_FE |=>
      s.rx_front_end_config == $past(avs_writedata_in[7:0]))
      else $error("rx front-end write lost");
   a_rx_low_bits: assert property (wr_go && avs_address_in == ADDR_RX_FE |=>
      fe_cfg_out.mixer_bias == $past(avs_writedata_in[1:0]))
      else $error("mixer bias not updated");
   a_tx_lo_write: assert property (wr_go && avs_address_in == ADDR_TX_FE |=>
      fe_cfg_out.tx_local_osc_buffer_bias == $past(avs_writedata_in[5:4]))
      else $error("tx lo buffer bias not updated");
   a_cal_cfg_write: assert property (wr_go && avs_address_in == ADDR_CAL_CP && !deep_sleep_wake_in |=>
      fe_cfg_out.cal_config == $past(avs_writedata_in[7:6]))
      else $error("calibration config not updated");
   a_cp_skip_hold: assert property (!cp_cal_stage_enable_out && cp_cal_done_in && !wr_go &&
      !deep_sleep_wake_in |=> $stable(s.synth_cal_charge_pump))
      else $error("skipped charge-pump stage changed result");
   a_cp_capture: assert property (cp_take && !deep_sleep_wake_in |=>
      fe_cfg_out.charge_pump_current == $past(cp_cal_result_in))
      else $error("charge-pump result not captured");
   a_core_select: assert property (wr_go && avs_address_in == ADDR_CAL_OSC && !deep_sleep_wake_in
      |=> fe_cfg_out.oscillator_core_select == $past(avs_writedata_in[5]))
      else $error("oscillator core select not updated");
   a_osc_capture: assert property (osc_cal_done_in && !deep_sleep_wake_in |=>
      fe_cfg_out.oscillator_current == $past(osc_cal_result_in))
      else $error("oscillator result not captured");
   a_wake_resets_cal: assert property (deep_sleep_wake_in |=>
      s.synth_cal_charge_pump == RST_CAL_CP && s.synth_cal_oscillator == RST_CAL_OSC)
      else $error("calibration registers not reset on wake");
   a_unused_zero: assert property ((s.tx_front_end_config & ~MASK_TX_FE) == 8'h00 &&
      (s.synth_cal_oscillator & ~MASK_CAL_OSC) == 8'h00)
      else $error("unused bits not zero");

   // priority in one cycle is wake, then hardware capture, then the software write
   a_wait_first: assert property (
      $rose(avs_read_in) || $rose(avs_write_in) |->
      avs_waitrequest_out)
      else $error("first cycle of a request not waited");

   a_wait_idle: assert property (
      !avs_read_in && !avs_write_in |->
      !avs_waitrequest_out)
      else $error("waitrequest high with no request");

   a_ack_one_cycle: assert property (
      s.ack |=>
      !s.ack)
      else $error("acknowledge held two cycles");

   a_read_rx: assert property (
      avs_read_in && avs_waitrequest_out && hit_rx |=>
      avs_readdata_out[7:0] == $past(s.rx_front_end_config))
      else $error("rx front-end read wrong");

   a_read_tx: assert property (
      avs_read_in && avs_waitrequest_out && hit_tx |=>
      avs_readdata_out[7:0] == $past(s.tx_front_end_config))
      else $error("tx front-end read wrong");

   a_read_cp: assert property (
      avs_read_in && avs_waitrequest_out && hit_cp |=>
      avs_readdata_out[7:0] == $past(s.synth_cal_charge_pump))
      else $error("charge-pump register read wrong");

   a_read_osc: assert property (
      avs_read_in && avs_waitrequest_out && hit_osc |=>
      avs_readdata_out[7:0] == $past(s.synth_cal_oscillator))
      else $error("oscillator register read wrong");

   a_read_unmapped: assert property (
      avs_read_in && avs_waitrequest_out && !hit_any |=>
      avs_readdata_out == 32'h00000000)
      else $error("unmapped read not zero");

   a_read_upper_zero: assert property (
      (avs_readdata_out[31:16] == 16'h0000) &&
      (avs_readdata_out[15:8] == 8'h00))
      else $error("upper read lanes not zero");

   a_read_stands: assert property (
      !(avs_read_in && avs_waitrequest_out) |=>
      $stable(avs_readdata_out))
      else $error("read data changed without a read");

   a_unmapped_write_dropped: assert property (
      avs_write_in && !avs_waitrequest_out && !hit_any |=>
      $stable(s.rx_front_end_config) && $stable(s.tx_front_end_config))
      else $error("unmapped write changed a register");

   a_byte_lane_gate: assert property (
      avs_write_in && !avs_waitrequest_out && !avs_byteenable_in[0] |=>
      $stable(s.rx_front_end_config) && $stable(s.tx_front_end_config))
      else $error("write landed with lane zero disabled");

   a_rx_lna_bias: assert property (
      wr_go && hit_rx |=>
      fe_cfg_out.low_noise_amp_bias == $past(avs_writedata_in[7:6]))
      else $error("low-noise amp bias not updated");

   a_rx_mixer_feed: assert property (
      wr_go && hit_rx |=>
      fe_cfg_out.amp_to_mixer_bias == $past(avs_writedata_in[5:4]))
      else $error("amp-to-mixer bias not updated");

   a_rx_lo_bias: assert property (
      wr_go && hit_rx |=>
      fe_cfg_out.rx_local_osc_buffer_bias == $past(avs_writedata_in[3:2]))
      else $error("rx lo buffer bias not updated");

   a_rx_hold: assert property (
      !(wr_go && hit_rx) |=>
      $stable(s.rx_front_end_config))
      else $error("rx front-end changed without a write");

   a_tx_hold: assert property (
      !(wr_go && hit_tx) |=>
      $stable(s.tx_front_end_config))
      else $error("tx front-end changed without a write");

   a_tx_reserved_kept: assert property (
      wr_go && hit_tx |=>
      fe_cfg_out.tx_reserved == $past(avs_writedata_in[2:0]))
      else $error("tx reserved bits not stored");

   a_cal_cfg_hold: assert property (
      !(wr_go && hit_cp) && !deep_sleep_wake_in |=>
      $stable(fe_cfg_out.cal_config))
      else $error("calibration config changed without a write");

   a_cp_enable_write: assert property (
      wr_go && hit_cp && !deep_sleep_wake_in |=>
      fe_cfg_out.charge_pump_cal_enable == $past(avs_writedata_in[5:4]))
      else $error("charge-pump stage enable not updated");

   a_cp_enable_hold: assert property (
      !(wr_go && hit_cp) && !deep_sleep_wake_in |=>
      $stable(fe_cfg_out.charge_pump_cal_enable))
      else $error("charge-pump stage enable changed without a write");

   a_cp_stage_out: assert property (
      cp_cal_stage_enable_out ==
      (fe_cfg_out.charge_pump_cal_enable != 2'h0))
      else $error("stage enable output disagrees with field");

   a_cp_result_hold: assert property (
      !cp_take && !(wr_go && hit_cp) && !deep_sleep_wake_in |=>
      $stable(fe_cfg_out.charge_pump_current))
      else $error("charge-pump result changed without a cause");

   a_cp_override: assert property (
      wr_go && hit_cp && !cp_take && !deep_sleep_wake_in |=>
      fe_cfg_out.charge_pump_current == $past(avs_writedata_in[3:0]))
      else $error("charge-pump override not stored");

   a_cp_cfg_kept: assert property (
      cp_take && !deep_sleep_wake_in && !(wr_go && hit_cp) |=>
      $stable(fe_cfg_out.cal_config) && $stable(fe_cfg_out.charge_pump_cal_enable))
      else $error("capture disturbed calibration config");

   a_core_hold: assert property (
      !(wr_go && hit_osc) && !deep_sleep_wake_in |=>
      $stable(fe_cfg_out.oscillator_core_select))
      else $error("core select changed without a write");

   a_osc_override: assert property (
      wr_go && hit_osc && !osc_cal_done_in && !deep_sleep_wake_in |=>
      fe_cfg_out.oscillator_current == $past(avs_writedata_in[4:0]))
      else $error("oscillator override not stored");

   a_osc_result_hold: assert property (
      !osc_cal_done_in && !(wr_go && hit_osc) && !deep_sleep_wake_in |=>
      $stable(fe_cfg_out.oscillator_current))
      else $error("oscillator result changed without a cause");

   a_wake_osc_default: assert property (
      deep_sleep_wake_in |=>
      fe_cfg_out.oscillator_current == RST_CAL_OSC[4:0])
      else $error("oscillator result not reset on wake");

   a_wake_stage_on: assert property (
      deep_sleep_wake_in |=>
      cp_cal_stage_enable_out)
      else $error("charge-pump stage not enabled after wake");

   a_wake_core_low: assert property (
      deep_sleep_wake_in |=>
      !fe_cfg_out.oscillator_core_select)
      else $error("low core not selected after wake");

   a_wake_keeps_fe: assert property (
      deep_sleep_wake_in && !wr_go |=>
      $stable(s.rx_front_end_config) && $stable(s.tx_front_end_config))
      else $error("wake disturbed front-end registers");

   a_tx_unused_read: assert property (
      avs_read_in && avs_waitrequest_out && hit_tx |=>
      avs_readdata_out[7:6] == 2'h0 && !avs_readdata_out[3])
      else $error("tx unused bits read nonzero");

   a_osc_unused_read: assert property (
      avs_read_in && avs_waitrequest_out && hit_osc |=>
      avs_readdata_out[7:6] == 2'h0)
      else $error("oscillator unused bits read nonzero");

   c_read_done:   cover property (avs_read_in && avs_waitrequest_out ##1 avs_read_in && !avs_waitrequest_out);
   c_write_done:  cover property (wr_go);
   c_wake:        cover property (deep_sleep_wake_in);
   c_cp_capture:  cover property (cp_take);
   c_cp_skip:     cover property (cp_cal_done_in && !cp_cal_stage_enable_out);
endmodule : rfsc_regs
`default_nettype wire

// ==== verification/rfsc_regs_test.sv ====
// self-checking bench for the front-end bias and synthesizer calibration register bank
// assumes rfsc_pkg is compiled first; the bench drives every port of rfsc_regs itself
`timescale 1ns/1ps
`default_nettype none
module rfsc_regs_test;
   import rfsc_pkg::*;
   logic                core_clk_in         = 1'b0;
   logic                reset_n_in          = 1'b0;
   logic [ADDR_W-1:0]   avs_address_in      = '0;
   logic                avs_read_in         = 1'b0;
   logic                avs_write_in        = 1'b0;
   logic [31:0]         avs_writedata_in    = '0;
   logic [3:0]          avs_byteenable_in   = '0;
   logic [3:0]          cp_cal_result_in    = '0;
   logic [4:0]          osc_cal_result_in   = '0;
   logic                cp_cal_done_in      = 1'b0;
   logic                osc_cal_done_in     = 1'b0;
   logic                deep_sleep_wake_in  = 1'b0;
   logic [31:0]         avs_readdata_out;
   logic                avs_waitrequest_out;
   logic                cp_cal_stage_enable_out;
   rfsc_fe_cfg_t        fe_cfg_out;
   logic [17:0]         adr [4] = '{ADDR_RX_FE, ADDR_TX_FE, ADDR_CAL_CP, ADDR_CAL_OSC};
   logic [7:0]          rs  [4] = '{RST_RX_FE, RST_TX_FE, RST_CAL_CP, RST_CAL_OSC};
   logic [7:0]          mk  [4] = '{MASK_RX_FE, MASK_TX_FE, MASK_CAL_CP, MASK_CAL_OSC};
   logic [7:0]          m   [4];
   logic [7:0]          sv2, sv3;
   logic [31:0]         q, d;
   logic [3:0]          be;
   int                  fail_count = 0;
   int                  cmp_count  = 0;
   int                  i;
   rfsc_regs dut_u (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .avs_address_in(avs_address_in),
      .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
      .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
      .avs_waitrequest_out(avs_waitrequest_out), .cp_cal_done_in(cp_cal_done_in),
      .cp_cal_result_in(cp_cal_result_in), .osc_cal_done_in(osc_cal_done_in),
      .osc_cal_result_in(osc_cal_result_in), .deep_sleep_wake_in(deep_sleep_wake_in),
      .cp_cal_stage_enable_out(cp_cal_stage_enable_out), .fe_cfg_out(fe_cfg_out));
   initial begin
      forever #2.5 core_clk_in = ~core_clk_in;
   end
   task automatic finish_test();
      $display("counts: %0d compares, %0d mismatches", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : finish_test
   task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: read %h expected %h", $time, got, exp);
      end
   endtask : chk_rd
   // outputs settle after the edge, so compare on the falling edge
   task automatic chk_cfg();
      logic [26:0] exp;
      @(negedge core_clk_in);
      exp = {m[0], m[1][5:4], m[1][2:0], m[2], m[3][5:0]};
      cmp_count++;
      if (fe_cfg_out !== exp || cp_cal_stage_enable_out !== (|m[2][5:4])) begin
         fail_count++;
         $display("mismatch at %0t: config %h expected %h", $time, fe_cfg_out, exp);
      end
   endtask : chk_cfg
   // one access; held until waitrequest is sampled low, bounded against a hang
   task automatic bus_op(input logic w, input logic [17:0] a, input logic [7:0] wd, input logic [3:0] b,
                         output logic [31:0] rq);
      int n;
      @(posedge core_clk_in);
      avs_address_in <= a;
      avs_writedata_in <= {24'($urandom), wd};
      avs_byteenable_in <= b;
      avs_write_in <= w;
      avs_read_in <= ~w;
      n = 0;
      do begin
         @(posedge core_clk_in);
         n++;
      end while (avs_waitrequest_out !== 1'b0 && n < 20);
      rq = avs_readdata_out;
      avs_read_in <= 1'b0;
      avs_write_in <= 1'b0;
      if (avs_waitrequest_out !== 1'b0) begin
         fail_count++;
         $display("mismatch at %0t: bus answer never came", $time);
         finish_test();
      end
   endtask : bus_op
   // one-cycle pulses on the calibration and wake inputs, model updated alongside
   task automatic pulse(input logic cp, input logic osc, input logic wake);
      logic [3:0] cr;
      logic [4:0] orr;
      cr = 4'($urandom);
      orr = 5'($urandom);
      @(posedge core_clk_in);
      cp_cal_done_in <= cp;
      osc_cal_done_in <= osc;
      deep_sleep_wake_in <= wake;
      cp_cal_result_in <= cr;
      osc_cal_result_in <= orr;
      @(posedge core_clk_in);
      {cp_cal_done_in, osc_cal_done_in, deep_sleep_wake_in} <= 3'h0;
      if (cp && m[2][5:4] != 2'h0) m[2][3:0] = cr;
      if (osc) m[3][4:0] = orr;
      if (wake) m[2] = rs[2];
      if (wake) m[3] = rs[3];
      chk_cfg();
   endtask : pulse
   initial begin
      void'($urandom(85));
      m = rs;
      repeat (4) @(posedge core_clk_in);
      reset_n_in <= 1'b1;
      for (i = 0; i < 4; i++) begin
         bus_op(1'b0, adr[i], 8'h00, 4'hF, q);
         chk_rd(q, {24'h0, rs[i]});
      end
      chk_cfg();
      $display("reset values test done");
      repeat (40) begin
         i = $urandom % 4;
         d = $urandom;
         be = 4'($urandom);
         if (i == 1) d[2:0] = 3'h0;
         bus_op(1'b1, adr[i], d[7:0], be, q);
         if (be[0]) m[i] = d[7:0] & mk[i];
         bus_op(1'b0, adr[i], 8'h00, 4'hF, q);
         chk_rd(q, {24'h0, m[i]});
         chk_cfg();
      end
      // unmapped neighbour address: write dropped, read gives zero
      bus_op(1'b1, 18'h37C78, 8'($urandom), 4'hF, q);
      bus_op(1'b0, 18'h37C78, 8'h00, 4'hF, q);
      chk_rd(q, 32'h0);
      chk_cfg();
      $display("register access test done");
      for (i = 0; i < 4; i++) begin
         m[2] = {2'h2, 2'(i), 4'h5};
         bus_op(1'b1, adr[2], m[2], 4'h1, q);
         pulse(1'b1, 1'b1, 1'b0);
      end
      $display("calibration capture test done");
      sv2 = m[2];
      sv3 = m[3];
      pulse(1'b1, 1'b1, 1'b1);
      bus_op(1'b0, adr[0], 8'h00, 4'hF, q);
      chk_rd(q, {24'h0, m[0]});
      bus_op(1'b1, adr[2], sv2, 4'h1, q);
      bus_op(1'b1, adr[3], sv3, 4'h1, q);
      m[2] = sv2;
      m[3] = sv3;
      bus_op(1'b0, adr[3], 8'h00, 4'hF, q);
      chk_rd(q, {24'h0, sv3});
      chk_cfg();
      $display("wake and restore test done");
      finish_test();
   end
endmodule : rfsc_regs_test
`default_nettype wire
